// File: design/power_mode_command_timer.sv
/*
 * Power mode command handling (idle, idle immediate, standby) with auto power-down timer.
 * Assumes host accesses arrive as one-cycle same-clock strobes on the task-file port and
 * that spin-up and spin-down finish within the fixed SPIN_UP_DIV and SPIN_DOWN_DIV cycle counts.
 */
`timescale 1ns/100ps
// How it works
// - Codes 97h and E3h in the command register start the idle command with timer option.
// - Idle sets busy, enters idle, then clears busy and raises the interrupt without waiting for spin-up.
// - Idle with the spindle already turning issues no spin-up request.
// - Idle with nonzero sector count enables the timer and starts it at once; zero disables it.
// - An enabled countdown that runs out with no command puts the drive into standby.
// - Any command reloads the timer and the countdown resumes from full only after completion.
// - Codes 1-3 give 15 s and codes 4-240 give code times 5 s.
// - Codes 241-251 give (code-240) half hours, 252 gives 21 min, 253 gives 8 h, 254-255 give 21 min 15 s.
// - Codes 95h and E1h run idle immediate with the usual busy and interrupt handshake.
// - Idle immediate leaves the timer setting untouched.
// - Codes 96h and E2h run standby and interrupt without waiting for spin-down.
// - Standby with the spindle already stopped issues no spin-down request.
// - Standby with nonzero sector count enables the timer, counting only after a return to idle.
// - When the running timer reaches zero the drive enters standby.
// - In standby a seek command first spins the spindle up and only then is handed on.
module power_mode_command_timer
    import power_mode_pkg::*;
#(
    parameter int  TICK_DIV      = int'(TICK_CYCLES),
    parameter int  SPIN_UP_DIV   = int'(SPIN_UP_CYCLES),
    parameter int  SPIN_DOWN_DIV = int'(SPIN_DOWN_CYCLES),
    parameter logic DRIVE_ID     = 1'b0
)
(
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [9:0] reg_address,
    input  wire logic [7:0] reg_write_data,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [7:0]      reg_read_data,
    output logic            interrupt_request,
    output logic            spindle_run,
    output logic            seek_command_go,
    output logic            standby_mode,
    input  wire logic       seek_command_done
);
    typedef enum logic [2:0] {
        S_READY     = 3'b000,
        S_BUSY      = 3'b001,
        S_SPIN_UP   = 3'b010,
        S_SEEK_RUN  = 3'b011,
        S_SPIN_DOWN = 3'b100
    } state_t;

    typedef enum logic [1:0] {
        C_NONE    = 2'b00,
        C_IDLE    = 2'b01,
        C_STANDBY = 2'b10,
        C_SEEK    = 2'b11
    } cmd_kind_t;

    function automatic logic [TICK_W-1:0] period_ticks(input logic [7:0] code);
        logic [TICK_W-1:0] ticks;
        ticks = '0;
        if (code <= CODE_SHORT_MAX)
            ticks = TICK_W'(PERIOD_15S_TICKS);
        else if (code <= CODE_STEP5_MAX)
            ticks = TICK_W'(code);
        else if (code <= CODE_HALFHR_MAX)
            ticks = TICK_W'((code - CODE_STEP5_MAX) * HALFHR_TICKS);
        else if (code == CODE_21MIN)
            ticks = TICK_W'(MIN21_TICKS);
        else if (code == CODE_8HR)
            ticks = TICK_W'(HR8_TICKS);
        else
            ticks = TICK_W'(MIN21S15_TICKS);
        return ticks;
    endfunction : period_ticks

    state_t            state;
    state_t            next_state;
    logic [7:0]        feature;
    logic [7:0]        sector_count;
    logic [7:0]        sector_number;
    logic [7:0]        cylinder_low;
    logic [7:0]        cylinder_high;
    logic [7:0]        drive_head;
    logic [7:0]        status;
    logic [7:0]        next_feature;
    logic [7:0]        next_sector_count;
    logic [7:0]        next_sector_number;
    logic [7:0]        next_cylinder_low;
    logic [7:0]        next_cylinder_high;
    logic [7:0]        next_drive_head;
    logic [7:0]        next_status;
    logic [7:0]        next_read_data;
    logic              next_interrupt;
    logic              next_spindle_run;
    logic              next_seek_go;
    logic              next_standby_mode;
    logic              timer_enable;
    logic              next_timer_enable;
    logic [TICK_W-1:0] timer_period;
    logic [TICK_W-1:0] next_timer_period;
    logic [TICK_W-1:0] timer_left;
    logic [TICK_W-1:0] next_timer_left;
    logic [31:0]       spin_count;
    logic [31:0]       next_spin_count;
    logic              tick;
    logic              counting;
    logic              selected;
    logic              cmd_write;
    cmd_kind_t         cmd_kind;

    assign selected  = drive_head[DRIVE_SELECT_BIT] == DRIVE_ID;
    assign cmd_write = reg_write && reg_address == command_and_status_reg && selected
                       && !status[ST_BSY];
    // Countdown only runs in idle with no command in flight
    assign counting  = timer_enable && !standby_mode && state == S_READY && !cmd_write;

    always_comb
    begin
        unique case (reg_write_data)
            CMD_IDLE_A, CMD_IDLE_B, CMD_IDLE_IMM_A, CMD_IDLE_IMM_B: cmd_kind = C_IDLE;
            CMD_STANDBY_A, CMD_STANDBY_B:                           cmd_kind = C_STANDBY;
            default:                                                cmd_kind = C_SEEK;
        endcase
    end

    power_tick_gen #(
        .TICK_DIV (TICK_DIV)
    ) u_tick (
        .clock (clock),
        .reset (reset),
        .run   (counting),
        .tick  (tick)
    );

    always_comb
    begin
        next_state         = state;
        next_feature       = feature;
        next_sector_count  = sector_count;
        next_sector_number = sector_number;
        next_cylinder_low  = cylinder_low;
        next_cylinder_high = cylinder_high;
        next_drive_head    = drive_head;
        next_status        = status;
        next_interrupt     = interrupt_request;
        next_spindle_run   = spindle_run;
        next_seek_go       = 1'b0;
        next_standby_mode  = standby_mode;
        next_timer_enable  = timer_enable;
        next_timer_period  = timer_period;
        next_timer_left    = timer_left;
        next_spin_count    = spin_count;
        next_read_data     = reg_read_data;

        if (reg_read)
        begin
            unique case (reg_address)
                error_and_feature_reg:  next_read_data = 8'h00;
                sector_count_reg:       next_read_data = sector_count;
                sector_number_reg:      next_read_data = sector_number;
                cylinder_low_reg:       next_read_data = cylinder_low;
                cylinder_high_reg:      next_read_data = cylinder_high;
                drive_head_select_reg:  next_read_data = drive_head;
                command_and_status_reg: next_read_data = status;
                default:                next_read_data = 8'h00;
            endcase
            if (reg_address == command_and_status_reg && selected)
                next_interrupt = 1'b0;
        end

        if (reg_write && !status[ST_BSY])
        begin
            unique case (reg_address)
                error_and_feature_reg:  next_feature       = reg_write_data;
                sector_count_reg:       next_sector_count  = reg_write_data;
                sector_number_reg:      next_sector_number = reg_write_data;
                cylinder_low_reg:       next_cylinder_low  = reg_write_data;
                cylinder_high_reg:      next_cylinder_high = reg_write_data;
                drive_head_select_reg:  next_drive_head    = reg_write_data;
                default:                next_feature       = feature;
            endcase
        end

        // Countdown
        if (counting && tick)
        begin
            if (timer_left <= TICK_W'(1))
            begin
                next_standby_mode = 1'b1;
                next_timer_left   = timer_period;
                if (spindle_run)
                begin
                    next_spin_count = 32'(SPIN_DOWN_DIV);
                    next_state      = S_SPIN_DOWN;
                    next_spindle_run = 1'b0;
                end
            end
            else
            begin
                next_timer_left = timer_left - TICK_W'(1);
            end
        end

        unique case (state)
            S_READY:
            begin
                if (cmd_write)
                begin
                    next_status[ST_BSY] = 1'b1;
                    next_status[ST_ERR] = 1'b0;
                    next_timer_left     = timer_period;
                    next_state          = S_BUSY;
                    if (cmd_kind == C_IDLE)
                    begin
                        next_standby_mode = 1'b0;
                        if (!spindle_run)
                            next_spindle_run = 1'b1;
                        if (reg_write_data == CMD_IDLE_A || reg_write_data == CMD_IDLE_B)
                        begin
                            next_timer_enable = sector_count != 8'h00;
                            next_timer_period = period_ticks(sector_count);
                            next_timer_left   = period_ticks(sector_count);
                        end // idle immediate keeps timer setting as is
                    end
                    else if (cmd_kind == C_STANDBY)
                    begin
                        next_standby_mode = 1'b1;
                        next_timer_enable = sector_count != 8'h00;
                        next_timer_period = period_ticks(sector_count);
                        next_timer_left   = period_ticks(sector_count);
                        if (spindle_run)
                        begin
                            next_spindle_run = 1'b0;
                            next_spin_count  = 32'(SPIN_DOWN_DIV);
                        end
                    end
                    else if (standby_mode)
                    begin
                        next_spindle_run = 1'b1;
                        next_spin_count  = 32'(SPIN_UP_DIV);
                        next_state       = S_SPIN_UP;
                    end
                    else
                    begin
                        next_seek_go = 1'b1;
                        next_state   = S_SEEK_RUN;
                    end
                end
            end
            S_BUSY:
            begin
                // Completion does not wait for the spindle
                next_status[ST_BSY] = 1'b0;
                next_interrupt      = 1'b1;
                next_state          = (spin_count != 32'h0) ? S_SPIN_DOWN : S_READY;
            end
            S_SPIN_UP:
            begin
                if (spin_count <= 32'h1)
                begin
                    next_spin_count   = 32'h0;
                    next_standby_mode = 1'b0;
                    next_seek_go      = 1'b1;
                    next_state        = S_SEEK_RUN;
                end
                else
                    next_spin_count = spin_count - 32'h1;
            end
            S_SEEK_RUN:
            begin
                if (seek_command_done)
                begin
                    next_status[ST_BSY] = 1'b0;
                    next_interrupt      = 1'b1;
                    next_timer_left     = timer_period;
                    next_state          = S_READY;
                end
            end
            S_SPIN_DOWN:
            begin
                if (spin_count <= 32'h1)
                begin
                    next_spin_count = 32'h0;
                    next_state      = S_READY;
                end
                else
                    next_spin_count = spin_count - 32'h1;
            end
            default:
                next_state = S_READY;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state             <= S_READY;
            feature           <= 8'h00;
            sector_count      <= 8'h01;
            sector_number     <= 8'h01;
            cylinder_low      <= 8'h00;
            cylinder_high     <= 8'h00;
            drive_head        <= 8'h00;
            status            <= STATUS_RESET;
            reg_read_data     <= 8'h00;
            interrupt_request <= 1'b0;
            spindle_run       <= 1'b1;
            seek_command_go   <= 1'b0;
            standby_mode      <= 1'b0;
            timer_enable      <= 1'b0;
            timer_period      <= '0;
            timer_left        <= '0;
            spin_count        <= 32'h0;
        end
        else
        begin
            state             <= next_state;
            feature           <= next_feature;
            sector_count      <= next_sector_count;
            sector_number     <= next_sector_number;
            cylinder_low      <= next_cylinder_low;
            cylinder_high     <= next_cylinder_high;
            drive_head        <= next_drive_head;
            status            <= next_status;
            reg_read_data     <= next_read_data;
            interrupt_request <= next_interrupt;
            spindle_run       <= next_spindle_run;
            seek_command_go   <= next_seek_go;
            standby_mode      <= next_standby_mode;
            timer_enable      <= next_timer_enable;
            timer_period      <= next_timer_period;
            timer_left        <= next_timer_left;
            spin_count        <= next_spin_count;
        end
    end
endmodule : power_mode_command_timer

// File: common/power_mode_pkg.sv
/*
 * Constants shared by the power mode command block: task-file offsets, status bits,
 * command codes, timer codes and time base.
 * Assumes a 25 MHz core clock.
 */
package power_mode_pkg;
    localparam logic [9:0] error_and_feature_reg  = 10'h1f1;
    localparam logic [9:0] sector_count_reg       = 10'h1f2;
    localparam logic [9:0] sector_number_reg      = 10'h1f3;
    localparam logic [9:0] cylinder_low_reg       = 10'h1f4;
    localparam logic [9:0] cylinder_high_reg      = 10'h1f5;
    localparam logic [9:0] drive_head_select_reg  = 10'h1f6;
    localparam logic [9:0] command_and_status_reg = 10'h1f7;

    localparam int ST_BSY  = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_ERR  = 0;
    localparam int DRIVE_SELECT_BIT = 4;

    localparam logic [7:0] CMD_IDLE_A       = 8'h97;
    localparam logic [7:0] CMD_IDLE_B       = 8'he3;
    localparam logic [7:0] CMD_IDLE_IMM_A   = 8'h95;
    localparam logic [7:0] CMD_IDLE_IMM_B   = 8'he1;
    localparam logic [7:0] CMD_STANDBY_A    = 8'h96;
    localparam logic [7:0] CMD_STANDBY_B    = 8'he2;

    localparam logic [7:0] CODE_SHORT_MAX   = 8'h03;
    localparam logic [7:0] CODE_STEP5_MAX   = 8'hf0;
    localparam logic [7:0] CODE_HALFHR_MAX  = 8'hfb;
    localparam logic [7:0] CODE_21MIN       = 8'hfc;
    localparam logic [7:0] CODE_8HR         = 8'hfd;

    // Periods counted in ticks of a 5 s time base
    localparam int TICK_SECONDS        = 5;
    localparam int PERIOD_15S_TICKS    = 15 / TICK_SECONDS;
    localparam int HALFHR_TICKS        = 1800 / TICK_SECONDS;
    localparam int MIN21_TICKS         = 1260 / TICK_SECONDS;
    localparam int HR8_TICKS           = 28800 / TICK_SECONDS;
    localparam int MIN21S15_TICKS      = 1275 / TICK_SECONDS;
    localparam int TICK_W              = 13;

    localparam int CLOCK_HZ            = 25_000_000;
    localparam longint TICK_CYCLES     = longint'(CLOCK_HZ) * TICK_SECONDS;
    localparam int SPIN_UP_MS          = 1000;
    localparam int SPIN_DOWN_MS        = 1000;
    localparam longint SPIN_UP_CYCLES  = longint'(CLOCK_HZ) / 1000 * SPIN_UP_MS;
    localparam longint SPIN_DOWN_CYCLES = longint'(CLOCK_HZ) / 1000 * SPIN_DOWN_MS;

    localparam logic [7:0] STATUS_RESET = 8'h40;
endpackage : power_mode_pkg

// File: design/power_tick_gen.sv
/*
 * Time base prescaler: one-cycle pulse every TICK_DIV clocks while run is high.
 * Assumes run is a same-clock level; dropping run restarts the phase.
 */
`timescale 1ns/100ps
module power_tick_gen
    import power_mode_pkg::*;
#(
    parameter int TICK_DIV = 125_000_000
)
(
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic run,
    output logic      tick
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic        next_tick;

    always_comb
    begin
        next_count = count;
        next_tick  = 1'b0;
        if (!run)
        begin
            next_count = 32'h0;
        end
        else if (count == 32'(TICK_DIV - 1))
        begin
            next_count = 32'h0;
            next_tick  = 1'b1;
        end
        else
        begin
            next_count = count + 32'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            count <= 32'h0;
            tick  <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule : power_tick_gen

// File: sim/power_mode_chk.sv
/* Checker for the power mode command block: command timing at the top ports.
   Assumes the host never writes while the drive is busy or spinning down. */
`timescale 1ns/100ps
module power_mode_chk
    import power_mode_pkg::*;
#(
    parameter logic DRIVE_ID = 1'b0
)
(
    input wire logic       clock,
    input wire logic       reset,
    input wire logic [9:0] reg_address,
    input wire logic [7:0] reg_write_data,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_read_data,
    input wire logic       interrupt_request,
    input wire logic       spindle_run,
    input wire logic       seek_command_go,
    input wire logic       standby_mode,
    input wire logic       seek_command_done
);
    logic dh_sel;
    logic next_dh_sel;
    logic cmd_wr;
    logic is_idle;
    logic is_stby;
    assign cmd_wr  = reg_write && reg_address == command_and_status_reg && dh_sel == DRIVE_ID;
    assign is_idle = reg_write_data inside {CMD_IDLE_A, CMD_IDLE_B, CMD_IDLE_IMM_A, CMD_IDLE_IMM_B};
    assign is_stby = reg_write_data inside {CMD_STANDBY_A, CMD_STANDBY_B};
    always_comb
    begin
        next_dh_sel = dh_sel;
        if (reg_write && reg_address == drive_head_select_reg)
            next_dh_sel = reg_write_data[DRIVE_SELECT_BIT];
    end
    always_ff @(posedge clock)
        dh_sel <= reset ? 1'b0 : next_dh_sel;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_power_irq: assert property (cmd_wr && (is_idle || is_stby) |-> ##2 interrupt_request)
        else $error("power command gave no interrupt");
    a_idle_spins: assert property (cmd_wr && is_idle |-> ##2 (spindle_run && !standby_mode))
        else $error("idle command left drive stopped");
    a_standby_stops: assert property (cmd_wr && is_stby |-> ##2 (standby_mode && !spindle_run))
        else $error("standby command did not stop spindle");
    a_idle_hold: assert property (cmd_wr && is_idle |-> ##2 (!standby_mode)[*8])
        else $error("standby came too soon after idle");
    a_go_spun: assert property (seek_command_go |-> spindle_run && $past(spindle_run, 2))
        else $error("command handed on before spin-up");
    a_go_pulse: assert property (seek_command_go |=> !seek_command_go)
        else $error("hand-on pulse too long");
    a_done_irq: assert property (seek_command_done |=> interrupt_request)
        else $error("no interrupt after media done");
    a_status_clear: assert property (reg_read && reg_address == command_and_status_reg && dh_sel == DRIVE_ID
        && !seek_command_done && !$past(cmd_wr) |=> !interrupt_request)
        else $error("status read did not clear interrupt");
    a_auto_stop: assert property ($rose(standby_mode) |-> !spindle_run)
        else $error("standby entered with spindle on");
endmodule : power_mode_chk

bind power_mode_command_timer power_mode_chk #(.DRIVE_ID(DRIVE_ID)) chk_u (
    .clock             (clock),
    .reset             (reset),
    .reg_address       (reg_address),
    .reg_write_data    (reg_write_data),
    .reg_write         (reg_write),
    .reg_read          (reg_read),
    .reg_read_data     (reg_read_data),
    .interrupt_request (interrupt_request),
    .spindle_run       (spindle_run),
    .seek_command_go   (seek_command_go),
    .standby_mode      (standby_mode),
    .seek_command_done (seek_command_done)
);

// File: sim/media_responder.sv
/* Media-side model: answers each handed-on command with a one-cycle done pulse.
   Assumes a one-cycle go pulse; the bench sets the answer delay. */
`timescale 1ns/100ps
module media_responder
(
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       seek_command_go,
    input  wire logic [7:0] resp_delay,
    output logic            seek_command_done
);
    initial seek_command_done = 1'b0;
    always @(posedge clock)
    begin
        if (!reset && seek_command_go)
        begin
            repeat (resp_delay) @(posedge clock);
            #1 seek_command_done = 1'b1;
            @(posedge clock);
            #1 seek_command_done = 1'b0;
        end
    end
endmodule : media_responder

// File: sim/test_power_mode_command_timer.sv
/* Self-checking bench for the power mode command block, time base shortened.
   Assumes the media responder model and the bound checker. */
`timescale 1ns/100ps
module test_power_mode_command_timer;
    import power_mode_pkg::*;
    localparam int TD = 4;
    localparam int SD = 3;
    logic       clock;
    logic       reset;
    logic [9:0] reg_address;
    logic [7:0] reg_write_data;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_read_data;
    logic       interrupt_request;
    logic       spindle_run;
    logic       seek_command_go;
    logic       standby_mode;
    logic       seek_command_done;
    logic [7:0] resp_delay;
    int         err_count;
    int         num_checks;

    power_mode_command_timer #(.TICK_DIV(TD), .SPIN_UP_DIV(SD), .SPIN_DOWN_DIV(SD)) dut_u (
        .clock(clock), .reset(reset), .reg_address(reg_address), .reg_write_data(reg_write_data),
        .reg_write(reg_write), .reg_read(reg_read), .reg_read_data(reg_read_data),
        .interrupt_request(interrupt_request), .spindle_run(spindle_run), .seek_command_go(seek_command_go),
        .standby_mode(standby_mode), .seek_command_done(seek_command_done));
    media_responder media_u (.clock(clock), .reset(reset), .seek_command_go(seek_command_go),
        .resp_delay(resp_delay), .seek_command_done(seek_command_done));

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t %s: saw %h wanted %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 reg_address = a;
        reg_write_data = d;
        reg_write = 1'b1;
        @(posedge clock);
        #1 reg_write = 1'b0;
    endtask : wr

    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clock);
        #1 reg_address = a;
        reg_read = 1'b1;
        @(posedge clock);
        #1 reg_read = 1'b0;
        d = reg_read_data;
    endtask : rd

    task automatic cmd(input logic [7:0] sc, input logic [7:0] dh, input logic [7:0] code);
        wr(sector_count_reg, sc);
        wr(drive_head_select_reg, dh);
        wr(command_and_status_reg, code);
    endtask : cmd

    // Waits for completion, then reads status, which must also drop the interrupt
    task automatic finish_cmd;
        int n;
        logic [7:0] d;
        n = 0;
        while (interrupt_request !== 1'b1 && n < 200)
        begin
            @(posedge clock);
            #1 n++;
        end
        chk(8'(interrupt_request), 8'h01, "no interrupt");
        rd(command_and_status_reg, d);
        chk(d & 8'h80, 8'h00, "still busy");
        chk(8'(interrupt_request), 8'h00, "interrupt not cleared");
    endtask : finish_cmd

    task automatic done_cmd(input logic [7:0] sc, input logic [7:0] code);
        cmd(sc, 8'h00, code);
        finish_cmd();
    endtask : done_cmd

    task automatic to_standby(input int limit, output int n);
        n = 0;
        while (standby_mode !== 1'b1 && n < limit)
        begin
            @(posedge clock);
            #1 n++;
        end
    endtask : to_standby

    function automatic int ticks(input int c);
        if (c <= 3) return 3;
        if (c <= 240) return c;
        if (c <= 251) return (c - 240) * 360;
        if (c == 252) return 252;
        if (c == 253) return 5760;
        return 255;
    endfunction : ticks

    task automatic t_reset;
        logic [9:0] a [6] = '{command_and_status_reg, sector_count_reg, sector_number_reg,
                              cylinder_low_reg, error_and_feature_reg, 10'h000};
        logic [7:0] e [6] = '{8'h40, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 6; i++)
        begin
            rd(a[i], d);
            chk(d, e[i], "reset value");
        end
        chk(8'({spindle_run, standby_mode}), 8'h02, "reset mode");
        wr(sector_count_reg, 8'h5a);
        rd(sector_count_reg, d);
        chk(d, 8'h5a, "count readback");
    endtask : t_reset

    task automatic t_select;
        cmd(8'h00, 8'h10, CMD_IDLE_A);
        repeat (6) @(posedge clock);
        chk(8'(interrupt_request), 8'h00, "other drive answered");
    endtask : t_select

    task automatic t_codes;
        int c [10] = '{1, 3, 4, 240, 241, 251, 252, 253, 254, 255};
        int n;
        for (int i = 0; i < 10; i++)
        begin
            done_cmd(8'(c[i]), i[0] ? CMD_IDLE_B : CMD_IDLE_A);
            to_standby(30000, n);
            chk(8'(n >= (ticks(c[i]) - 2) * TD && n <= (ticks(c[i]) + 1) * TD), 8'h01, "period");
            chk(8'(spindle_run), 8'h00, "spindle on in standby");
            repeat (10) @(posedge clock);
        end
    endtask : t_codes

    task automatic t_reload;
        int n;
        done_cmd(8'h08, CMD_IDLE_A);
        repeat (4) @(posedge clock);
        done_cmd(8'h00, CMD_IDLE_IMM_B);
        to_standby(200, n);
        chk(8'(n >= 6 * TD && n <= 9 * TD), 8'h01, "timer not reloaded");
        repeat (10) @(posedge clock);
    endtask : t_reload

    task automatic t_standby;
        int n;
        done_cmd(8'h00, CMD_IDLE_A);
        to_standby(2000, n);
        chk(8'(standby_mode), 8'h00, "timer not disabled");
        done_cmd(8'h02, CMD_STANDBY_B);
        chk(8'({standby_mode, spindle_run}), 8'h02, "no standby");
        repeat (10) @(posedge clock);
        done_cmd(8'h02, CMD_STANDBY_A);
        repeat (100) @(posedge clock);
        chk(8'({standby_mode, spindle_run}), 8'h02, "left standby");
        done_cmd(8'h00, CMD_IDLE_IMM_A);
        to_standby(200, n);
        chk(8'(n >= TD && n <= 4 * TD), 8'h01, "countdown after idle");
        repeat (10) @(posedge clock);
    endtask : t_standby

    task automatic t_seek;
        int n;
        logic [7:0] d;
        for (int k = 0; k < 2; k++)
        begin
            resp_delay = k ? 8'h00 : 8'h05;
            cmd(8'h01, 8'h00, 8'h20);
            n = 0;
            while (seek_command_go !== 1'b1 && n < 100)
            begin
                @(posedge clock);
                #1 n++;
            end
            chk(8'(seek_command_go && spindle_run), 8'h01, "no hand-on");
            chk(8'(k ? n <= 2 : n >= SD), 8'h01, "hand-on timing");
            rd(command_and_status_reg, d);
            chk(d & 8'h80, 8'h80, "not busy");
            finish_cmd();
            chk(8'(standby_mode), 8'h00, "still in standby");
        end
    endtask : t_seek

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    initial
    begin
        reset = 1'b1;
        reg_address = 10'h000;
        reg_write_data = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        resp_delay = 8'h00;
        err_count = 0;
        num_checks = 0;
        repeat (16) @(posedge clock);
        #1 reset = 1'b0;
        t_reset();
        t_select();
        t_codes();
        t_reload();
        t_standby();
        t_seek();
        close_out();
    end

    initial
    begin
        repeat (90000) @(posedge clock);
        err_count++;
        close_out();
    end
endmodule : test_power_mode_command_timer
